// File: design/pcfg_cfg.svh
// Register offsets, field positions, reset values and timing counts of the gate and overtemperature setup block.
`ifndef PCFG_CFG_SVH
`define PCFG_CFG_SVH

`define PCFG_ADDR_SETUP 16'hFE14
`define PCFG_ADDR_LIMITS 16'hFE15
`define PCFG_ADDR_OFS_HI 16'hFE16
`define PCFG_ADDR_OFS_LO 16'hFE17
`define PCFG_ADDR_GAIN 16'hFE18
`define PCFG_ADDR_OT_THR 16'hFE19

`define PCFG_SETUP_TOPO_BIT 4
`define PCFG_SETUP_RES_BIT 3
`define PCFG_SETUP_DIS1_BIT 2
`define PCFG_SETUP_DIS2_BIT 1
`define PCFG_SETUP_GO_BIT 0
`define PCFG_SETUP_USED_MASK 8'h1F
`define PCFG_SETUP_SINGLE_MASK 8'h0F
`define PCFG_LIM_ON_MSB 7
`define PCFG_LIM_ON_LSB 4
`define PCFG_LIM_OFF_MSB 3
`define PCFG_LIM_OFF_LSB 0
`define PCFG_OFS_SIGN_BIT 1
`define PCFG_OFS_MSB_BIT 0
`define PCFG_GAIN_SIGN_BIT 7

`define PCFG_RST_SETUP 8'h06
`define PCFG_RST_LIMITS 8'h00
`define PCFG_RST_OFS_HI 8'h00
`define PCFG_RST_OFS_LO 8'h00
`define PCFG_RST_GAIN 8'h00
`define PCFG_RST_OT_THR 8'h03

`define PCFG_FINE_STEP_NS 8'h05
`define PCFG_COARSE_STEP_NS 8'h28
`define PCFG_ON_STEP_NS 11'h050
`define PCFG_OFF_ZERO_NS 11'h028

`define PCFG_CLK_KHZ 125000
`define PCFG_OT_DEBOUNCE_MS 100
`define PCFG_OT_DEBOUNCE_CYC (`PCFG_OT_DEBOUNCE_MS * `PCFG_CLK_KHZ)

`endif

// File: design/pcfg_pkg.sv
// Types shared by the gate and overtemperature setup block.
package pcfg_pkg;
  typedef logic [7:0] pcfg_byte_t;
  typedef enum logic {PCFG_INTERLEAVED, PCFG_BRIDGELESS} pcfg_topo_t;
  typedef enum logic [1:0] {PCFG_GATE_OFF, PCFG_GATE_ARMED, PCFG_GATE_RUN} pcfg_gate_t;
endpackage

// File: design/pcfg_debounce.sv
// Persistence filter: flag rises only after the condition has held for a full count.
`timescale 1ns/1ns
`include "pcfg_cfg.svh"
module pcfg_debounce #(
  parameter int unsigned HOLD_CYC = `PCFG_OT_DEBOUNCE_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Condition and filtered flag
  input wire logic cond,
  output logic flag
);
  localparam int CW = $clog2(HOLD_CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(HOLD_CYC - 1);

  logic [CW-1:0] cnt_q, cnt_d;
  logic flag_q, flag_d;

  always_comb begin
    cnt_d = cnt_q;
    flag_d = flag_q;
    if (!cond) begin
      cnt_d = '0;
      flag_d = 1'b0;
    end else if (!flag_q) begin
      if (cnt_q == LAST) begin
        flag_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      cnt_q <= '0;
      flag_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      flag_q <= flag_d;
    end
  end

  assign flag = flag_q;
endmodule // pcfg_debounce

// File: design/pcfg_regs.sv
// Gate output setup, switch time bounds, temperature trims and overtemperature fault detection.
`timescale 1ns/1ns
`include "pcfg_cfg.svh"
module pcfg_regs import pcfg_pkg::*; #(
  parameter bit DUAL_PHASE = 1'b1,
  parameter int unsigned ADC_W = 12,
  parameter int unsigned GAIN_SHIFT = 10,
  parameter int unsigned EDGE_W = 64,
  parameter int unsigned OT_HOLD_CYC = `PCFG_OT_DEBOUNCE_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Register access from the serial bus command decoder
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [15:0] regAddr,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  output logic regRdValid,
  output logic regWrRefused,
  // Trim unlock state from the unlock logic
  input wire logic trimUnlock,
  // Edge timing group, staged and committed
  input wire logic [EDGE_W-1:0] edgeTimingStaged,
  output logic [EDGE_W-1:0] edgeTimingActive,
  // Committed switching settings
  output logic activeBridgeless,
  output logic [7:0] activeStepNs,
  output logic [10:0] minOnNs,
  output logic [10:0] minOffNs,
  output logic settingsUpdated,
  // Gate outputs
  input wire logic periodStart,
  input wire logic firstGateRaw,
  input wire logic secondGateRaw,
  output logic firstGateOut,
  output logic second_switching_output,
  // Temperature path
  input wire logic tempValid,
  input wire logic [ADC_W-1:0] tempAdc,
  output logic [ADC_W-1:0] tempCorrected,
  output logic overtempFault
);
  localparam pcfg_byte_t SETUP_MASK = DUAL_PHASE ? `PCFG_SETUP_USED_MASK : `PCFG_SETUP_SINGLE_MASK;
  localparam int SW = ADC_W + 3;
  localparam logic signed [SW-1:0] ADC_MAX = SW'((1 << ADC_W) - 1);

  // Register file.
  pcfg_byte_t setup_q, setup_d, limits_q, limits_d;
  pcfg_byte_t ofsHi_q, ofsHi_d, ofsLo_q, ofsLo_d;
  pcfg_byte_t gain_q, gain_d, otThr_q, otThr_d;
  pcfg_byte_t rdData_q, rdData_d;
  logic rdValid_q, rdValid_d, refused_q, refused_d;

  logic hitSetup, hitLimits, hitOfsHi, hitOfsLo, hitGain, hitOtThr, trimHit;

  always_comb begin
    hitSetup = 1'b0;
    hitLimits = 1'b0;
    hitOfsHi = 1'b0;
    hitOfsLo = 1'b0;
    hitGain = 1'b0;
    hitOtThr = 1'b0;
    if (regAddr == `PCFG_ADDR_SETUP) begin
      hitSetup = 1'b1;
    end else if (regAddr == `PCFG_ADDR_LIMITS) begin
      hitLimits = 1'b1;
    end else if (regAddr == `PCFG_ADDR_OFS_HI) begin
      hitOfsHi = 1'b1;
    end else if (regAddr == `PCFG_ADDR_OFS_LO) begin
      hitOfsLo = 1'b1;
    end else if (regAddr == `PCFG_ADDR_GAIN) begin
      hitGain = 1'b1;
    end else if (regAddr == `PCFG_ADDR_OT_THR) begin
      hitOtThr = 1'b1;
    end
    trimHit = hitOfsHi | hitOfsLo | hitGain;
  end

  always_comb begin
    setup_d = setup_q;
    limits_d = limits_q;
    ofsHi_d = ofsHi_q;
    ofsLo_d = ofsLo_q;
    gain_d = gain_q;
    otThr_d = otThr_q;
    refused_d = 1'b0;
    if (regWrEn) begin
      if (hitSetup) begin
        setup_d = regWrData & SETUP_MASK;
      end else if (hitLimits) begin
        limits_d = regWrData;
      end else if (hitOtThr) begin
        otThr_d = regWrData;
      end else if (trimHit && !trimUnlock) begin
        refused_d = 1'b1;
      end else if (hitOfsHi) begin
        ofsHi_d = regWrData;
      end else if (hitOfsLo) begin
        ofsLo_d = regWrData;
      end else if (hitGain) begin
        gain_d = regWrData;
      end
    end
    rdValid_d = regRdEn;
    rdData_d = '0;
    if (regRdEn) begin
      if (hitSetup) begin
        rdData_d = setup_q;
      end else if (hitLimits) begin
        rdData_d = limits_q;
      end else if (hitOfsHi) begin
        rdData_d = ofsHi_q;
      end else if (hitOfsLo) begin
        rdData_d = ofsLo_q;
      end else if (hitGain) begin
        rdData_d = gain_q;
      end else if (hitOtThr) begin
        rdData_d = otThr_q;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      setup_q <= `PCFG_RST_SETUP & SETUP_MASK;
      limits_q <= `PCFG_RST_LIMITS;
      ofsHi_q <= `PCFG_RST_OFS_HI;
      ofsLo_q <= `PCFG_RST_OFS_LO;
      gain_q <= `PCFG_RST_GAIN;
      otThr_q <= `PCFG_RST_OT_THR;
      rdData_q <= '0;
      rdValid_q <= 1'b0;
      refused_q <= 1'b0;
    end else begin
      setup_q <= setup_d;
      limits_q <= limits_d;
      ofsHi_q <= ofsHi_d;
      ofsLo_q <= ofsLo_d;
      gain_q <= gain_d;
      otThr_q <= otThr_d;
      rdData_q <= rdData_d;
      rdValid_q <= rdValid_d;
      refused_q <= refused_d;
    end
  end

  // Commit of switching settings. Only a zero-to-one step of the go bit commits, so rewriting
  // a one, or leaving the bit high while other bits change, keeps the running waveform intact.
  logic goRise;
  logic [EDGE_W-1:0] edge_q, edge_d;
  logic topo_q, topo_d, fine_q, fine_d, dis1_q, dis1_d, dis2_q, dis2_d, upd_q, upd_d;
  logic [3:0] onCode_q, onCode_d, offCode_q, offCode_d;
  logic [7:0] step_q, step_d;
  logic [10:0] onNs_q, onNs_d, offNs_q, offNs_d;

  always_comb begin
    goRise = !setup_q[`PCFG_SETUP_GO_BIT] && setup_d[`PCFG_SETUP_GO_BIT];
    edge_d = edge_q;
    topo_d = topo_q;
    fine_d = fine_q;
    dis1_d = dis1_q;
    dis2_d = dis2_q;
    onCode_d = onCode_q;
    offCode_d = offCode_q;
    upd_d = goRise;
    if (goRise) begin
      edge_d = edgeTimingStaged;
      topo_d = DUAL_PHASE & setup_d[`PCFG_SETUP_TOPO_BIT];
      fine_d = setup_d[`PCFG_SETUP_RES_BIT];
      dis1_d = setup_d[`PCFG_SETUP_DIS1_BIT];
      dis2_d = setup_d[`PCFG_SETUP_DIS2_BIT];
      onCode_d = limits_q[`PCFG_LIM_ON_MSB:`PCFG_LIM_ON_LSB];
      offCode_d = limits_q[`PCFG_LIM_OFF_MSB:`PCFG_LIM_OFF_LSB];
    end
    step_d = fine_q ? `PCFG_FINE_STEP_NS : `PCFG_COARSE_STEP_NS;
    onNs_d = 11'(onCode_q) * `PCFG_ON_STEP_NS;
    offNs_d = (offCode_q == 4'h0) ? `PCFG_OFF_ZERO_NS : 11'(offCode_q) * `PCFG_ON_STEP_NS;
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      edge_q <= '0;
      topo_q <= PCFG_INTERLEAVED;
      fine_q <= 1'b0;
      dis1_q <= 1'b1;
      dis2_q <= 1'b1;
      onCode_q <= 4'h0;
      offCode_q <= 4'h0;
      upd_q <= 1'b0;
      step_q <= `PCFG_COARSE_STEP_NS;
      onNs_q <= 11'h000;
      offNs_q <= `PCFG_OFF_ZERO_NS;
    end else begin
      edge_q <= edge_d;
      topo_q <= topo_d;
      fine_q <= fine_d;
      dis1_q <= dis1_d;
      dis2_q <= dis2_d;
      onCode_q <= onCode_d;
      offCode_q <= offCode_d;
      upd_q <= upd_d;
      step_q <= step_d;
      onNs_q <= onNs_d;
      offNs_q <= offNs_d;
    end
  end

  // Gate output holding. An enabled output waits for the next period start so that it never
  // emits a truncated first pulse.
  pcfg_gate_t g1_q, g1_d, g2_q, g2_d;
  logic gOut1_q, gOut1_d, gOut2_q, gOut2_d;

  function automatic pcfg_gate_t gateNext(input pcfg_gate_t cur, input logic dis, input logic start);
    pcfg_gate_t nxt;
    nxt = cur;
    case (cur)
      PCFG_GATE_OFF: begin
        if (!dis) begin
          nxt = start ? PCFG_GATE_RUN : PCFG_GATE_ARMED;
        end
      end
      PCFG_GATE_ARMED: begin
        if (dis) begin
          nxt = PCFG_GATE_OFF;
        end else if (start) begin
          nxt = PCFG_GATE_RUN;
        end
      end
      default: begin
        if (dis) begin
          nxt = PCFG_GATE_OFF;
        end
      end
    endcase
    return nxt;
  endfunction

  always_comb begin
    g1_d = gateNext(g1_q, dis1_q, periodStart);
    g2_d = gateNext(g2_q, dis2_q, periodStart);
    gOut1_d = (g1_d == PCFG_GATE_RUN) && firstGateRaw;
    gOut2_d = (g2_d == PCFG_GATE_RUN) && secondGateRaw;
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      g1_q <= PCFG_GATE_OFF;
      g2_q <= PCFG_GATE_OFF;
      gOut1_q <= 1'b0;
      gOut2_q <= 1'b0;
    end else begin
      g1_q <= g1_d;
      g2_q <= g2_d;
      gOut1_q <= gOut1_d;
      gOut2_q <= gOut2_d;
    end
  end

  // Temperature correction: reading plus signed gain fraction, then signed offset, clamped.
  logic signed [SW-1:0] gainTerm, ofsTerm, sum;
  logic [ADC_W+6:0] prod;
  logic [8:0] ofsMag;
  logic [ADC_W-1:0] corr_q, corr_d;
  logic below_q, below_d;

  always_comb begin
    prod = (ADC_W + 7)'(tempAdc) * (ADC_W + 7)'(gain_q[6:0]);
    gainTerm = SW'(prod >> GAIN_SHIFT);
    if (gain_q[`PCFG_GAIN_SIGN_BIT]) begin
      gainTerm = -gainTerm;
    end
    ofsMag = {ofsHi_q[`PCFG_OFS_MSB_BIT], ofsLo_q};
    ofsTerm = ofsHi_q[`PCFG_OFS_SIGN_BIT] ? -SW'(ofsMag) : SW'(ofsMag);
    sum = SW'(tempAdc) + gainTerm + ofsTerm;
    corr_d = corr_q;
    if (tempValid) begin
      if (sum < 0) begin
        corr_d = '0;
      end else if (sum > ADC_MAX) begin
        corr_d = ADC_MAX[ADC_W-1:0];
      end else begin
        corr_d = sum[ADC_W-1:0];
      end
    end
    // A low voltage on the sensor means a hot part.
    below_d = corr_q[ADC_W-1:ADC_W-9] < {1'b0, otThr_q};
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      corr_q <= ADC_MAX[ADC_W-1:0];
      below_q <= 1'b0;
    end else begin
      corr_q <= corr_d;
      below_q <= below_d;
    end
  end

  logic otFlag;

  pcfg_debounce #(
    .HOLD_CYC(OT_HOLD_CYC)
  ) otFilter (
    .core_clk(core_clk),
    .nrst(nrst),
    .cond(below_q),
    .flag(otFlag)
  );

  assign regRdData = rdData_q;
  assign regRdValid = rdValid_q;
  assign regWrRefused = refused_q;
  assign edgeTimingActive = edge_q;
  assign activeBridgeless = topo_q;
  assign activeStepNs = step_q;
  assign minOnNs = onNs_q;
  assign minOffNs = offNs_q;
  assign settingsUpdated = upd_q;
  assign firstGateOut = gOut1_q;
  assign second_switching_output = gOut2_q;
  assign tempCorrected = corr_q;
  assign overtempFault = otFlag;
endmodule // pcfg_regs

// File: tb/pcfg_regs_properties.sv
// Checker on the ports of the setup block.
`timescale 1ns/1ns
module pcfg_regs_properties #(
  parameter int unsigned EDGE_W = 64
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Register bus
  input wire logic regWrEn,
  input wire logic [15:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrRefused,
  input wire logic trimUnlock,
  // Committed settings and gates
  input wire logic [EDGE_W-1:0] edgeTimingStaged,
  input wire logic [EDGE_W-1:0] edgeTimingActive,
  input wire logic activeBridgeless,
  input wire logic [7:0] activeStepNs,
  input wire logic [10:0] minOnNs,
  input wire logic [10:0] minOffNs,
  input wire logic settingsUpdated,
  input wire logic firstGateRaw,
  input wire logic firstGateOut,
  input wire logic second_switching_output
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // Mirrors of the stored go bit, the committed setup and the bounds taken at commit.
  logic [7:0] setup_q, setup_d, cfg_q, cfg_d, lim_q, lim_d, bnd_q, bnd_d;
  logic commit;
  logic trimWr;
  assign commit = regWrEn && regAddr == 16'hFE14 && regWrData[0] && !setup_q[0];
  assign trimWr = regWrEn && regAddr >= 16'hFE16 && regAddr <= 16'hFE18;
  always_comb begin
    setup_d = setup_q;
    lim_d = lim_q;
    cfg_d = cfg_q;
    bnd_d = bnd_q;
    if (regWrEn && regAddr == 16'hFE14) setup_d = regWrData;
    if (regWrEn && regAddr == 16'hFE15) lim_d = regWrData;
    if (commit) begin
      cfg_d = regWrData;
      bnd_d = lim_q;
    end
  end
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      setup_q <= 8'h06;
      cfg_q <= 8'h06;
      lim_q <= 8'h00;
      bnd_q <= 8'h00;
    end else begin
      setup_q <= setup_d;
      cfg_q <= cfg_d;
      lim_q <= lim_d;
      bnd_q <= bnd_d;
    end
  end
  sequence s_commit;
    commit ##1 settingsUpdated;
  endsequence
  a_commit_pulse: assert property (1 |=> settingsUpdated == $past(commit)) else $error("update pulse");
  a_topo_set: assert property (settingsUpdated |-> activeBridgeless == cfg_q[4]) else $error("topology");
  a_step_set: assert property (s_commit |=> activeStepNs == (cfg_q[3] ? 8'h05 : 8'h28)) else $error("step");
  a_on_set: assert property (s_commit |=> minOnNs == 11'(bnd_q[7:4]) * 11'h050) else $error("on time");
  a_off_set: assert property (s_commit |=> minOffNs == (bnd_q[3:0] == 4'h0 ? 11'h028 : 11'(bnd_q[3:0]) * 11'h050))
    else $error("off time");
  a_edge_take: assert property (settingsUpdated |-> edgeTimingActive == $past(edgeTimingStaged))
    else $error("edge group");
  a_first_off: assert property (cfg_q[2] && $past(cfg_q[2]) |-> !firstGateOut) else $error("first gate");
  a_second_off: assert property (cfg_q[1] && $past(cfg_q[1]) |-> !second_switching_output)
    else $error("second gate");
  a_gate_raw: assert property (firstGateOut |-> $past(firstGateRaw)) else $error("gate source");
  a_trim_refuse: assert property (1 |=> regWrRefused == $past(trimWr && !trimUnlock)) else $error("refuse");
endmodule // pcfg_regs_properties

bind pcfg_regs pcfg_regs_properties #(.EDGE_W(EDGE_W)) u_props (.*);

// File: tb/pcfg_host.sv
// Host model driving the register strobes of the setup block.
`timescale 1ns/1ns
module pcfg_host (
  // Clock
  input wire logic core_clk,
  // Register bus
  output logic regWrEn,
  output logic regRdEn,
  output logic [15:0] regAddr,
  output logic [7:0] regWrData,
  output logic trimUnlock,
  input wire logic [7:0] regRdData,
  input wire logic regRdValid
);
  initial begin
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    regAddr = 16'h0000;
    regWrData = 8'h00;
    trimUnlock = 1'b0;
  end
  task automatic unlock(input logic on);
    @(posedge core_clk);
    trimUnlock <= on;
  endtask
  // Released lines show the inverse so a design cannot lean on stale values.
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    if (a == 16'hFE19 && (d < 8'h03 || d > 8'hFA)) return;
    @(posedge core_clk);
    regWrEn <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge core_clk);
    regWrEn <= 1'b0;
    regAddr <= ~a;
    regWrData <= ~d;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic v);
    @(posedge core_clk);
    regRdEn <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRdEn <= 1'b0;
    regAddr <= ~a;
    @(posedge core_clk);
    d = regRdData;
    v = regRdValid;
  endtask
endmodule // pcfg_host

// File: tb/pcfg_regs_tb_top.sv
// Self-checking bench for the gate and overtemperature setup block.
`timescale 1ns/1ns
module pcfg_regs_tb_top;
  logic core_clk, nrst, regWrEn, regRdEn, regRdValid, regWrRefused, trimUnlock, v;
  logic [15:0] regAddr;
  logic [7:0] regWrData, regRdData, activeStepNs, d;
  logic [63:0] edgeTimingStaged, edgeTimingActive;
  logic activeBridgeless, settingsUpdated, periodStart, firstGateRaw, secondGateRaw;
  logic firstGateOut, second_switching_output, tempValid, overtempFault;
  logic [10:0] minOnNs, minOffNs;
  logic [11:0] tempAdc, tempCorrected;
  int miscompares = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [15:0] rAddr [7] = '{16'hFE14, 16'hFE15, 16'hFE16, 16'hFE17, 16'hFE18, 16'hFE19, 16'hFE1A};
  logic [7:0] rVal [7] = '{8'h06, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h00};
  // Offset high, offset low, gain, reading, trimmed reading.
  logic [47:0] trims [4] = '{48'h010000800900, 48'h030000800700, 48'h000040800880, 48'h0000C0800780};
  pcfg_regs #(.OT_HOLD_CYC(20)) DUT (.*);
  pcfg_host host (.*);
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      miscompares++;
      print_verdict();
    end
  end
  task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rdc(input logic [15:0] a, input logic [7:0] exp);
    host.rd(a, d, v);
    check("valid", v, 1'b1);
    check("data", d, exp);
  endtask
  task automatic temp(input logic [11:0] a);
    @(posedge core_clk);
    tempValid <= 1'b1;
    tempAdc <= a;
    @(posedge core_clk);
    tempValid <= 1'b0;
    tempAdc <= ~a;
    repeat (2) @(posedge core_clk);
  endtask
  task automatic pulse();
    periodStart <= 1'b1;
    @(posedge core_clk);
    periodStart <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask
  task automatic print_verdict();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    nrst <= 1'b0;
    edgeTimingStaged <= 64'h0;
    periodStart <= 1'b0;
    firstGateRaw <= 1'b0;
    secondGateRaw <= 1'b0;
    tempValid <= 1'b0;
    tempAdc <= 12'h000;
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    for (int i = 0; i < 7; i++) rdc(rAddr[i], rVal[i]);
    host.wr(16'hFE15, 8'hF0);
    edgeTimingStaged <= 64'h0123456789ABCDEF;
    host.wr(16'hFE14, 8'hF9);
    rdc(16'hFE14, 8'h19);
    check("bridgeless", activeBridgeless, 1'b1);
    check("fine", activeStepNs, 8'h05);
    check("on max", minOnNs, 11'h4B0);
    check("off zero", minOffNs, 11'h028);
    check("edges", edgeTimingActive, 64'h0123456789ABCDEF);
    host.wr(16'hFE15, 8'h01);
    host.wr(16'hFE14, 8'h09);
    rdc(16'hFE15, 8'h01);
    check("held", minOnNs, 11'h4B0);
    host.wr(16'hFE14, 8'h00);
    host.wr(16'hFE14, 8'h01);
    rdc(16'hFE14, 8'h01);
    check("interleaved", activeBridgeless, 1'b0);
    check("coarse", activeStepNs, 8'h28);
    check("on none", minOnNs, 11'h000);
    check("off one", minOffNs, 11'h050);
    firstGateRaw <= 1'b1;
    secondGateRaw <= 1'b1;
    repeat (3) @(posedge core_clk);
    check("armed", firstGateOut, 1'b0);
    pulse();
    check("first on", firstGateOut, 1'b1);
    check("second on", second_switching_output, 1'b1);
    host.wr(16'hFE14, 8'h04);
    host.wr(16'hFE14, 8'h05);
    pulse();
    check("first off", firstGateOut, 1'b0);
    check("second runs", second_switching_output, 1'b1);
    host.wr(16'hFE14, 8'h02);
    host.wr(16'hFE14, 8'h03);
    @(posedge core_clk);
    check("update", settingsUpdated, 1'b1);
    @(posedge core_clk);
    check("first armed", firstGateOut, 1'b0);
    pulse();
    check("first again", firstGateOut, 1'b1);
    check("second off", second_switching_output, 1'b0);
    host.wr(16'hFE18, 8'h40);
    @(posedge core_clk);
    check("refused", regWrRefused, 1'b1);
    rdc(16'hFE18, 8'h00);
    host.unlock(1'b1);
    foreach (trims[i]) begin
      host.wr(16'hFE16, trims[i][47:40]);
      host.wr(16'hFE17, trims[i][39:32]);
      host.wr(16'hFE18, trims[i][31:24]);
      temp(trims[i][23:12]);
      check("trimmed", tempCorrected, trims[i][11:0]);
    end
    host.wr(16'hFE18, 8'h00);
    host.wr(16'hFE19, 8'h20);
    // Reading 0x0F8 sits one threshold step, eight codes, under the threshold, 0x100 exactly on it.
    temp(12'h0F8);
    repeat (19) @(posedge core_clk);
    check("fault early", overtempFault, 1'b0);
    repeat (1) @(posedge core_clk);
    check("fault set", overtempFault, 1'b1);
    temp(12'h100);
    repeat (2) @(posedge core_clk);
    check("fault clear", overtempFault, 1'b0);
    print_verdict();
  end
endmodule // pcfg_regs_tb_top
